// file: csb_params.svh
// constants for the control switch and button block
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH
`define CSB_NUM_SWITCH 5
`define CSB_NUM_BUTTON 12
`define CSB_NUM_SOURCE 16
`define CSB_SRC_SEL_W 4
`define CSB_LEVEL_DEFAULT 2'h2
`define CSB_DEBOUNCE_NS 2000
`define CSB_CLK_PERIOD_NS 4
`define CSB_DEBOUNCE_CYC ((`CSB_DEBOUNCE_NS + `CSB_CLK_PERIOD_NS - 1) / `CSB_CLK_PERIOD_NS)
`define CSB_DEB_CNT_W 9
`endif

// file: csb_pkg.sv
// types for the control switch and button block
package csb_pkg;
   // session / required access level
   typedef enum logic [1:0] {
      CSB_LVL_USER = 2'h0,
      CSB_LVL_OPERATOR = 2'h1,
      CSB_LVL_CONFIGURATOR = 2'h2,
      CSB_LVL_SUPER = 2'h3
   } csb_level_e;
   // one switch command from a source
   typedef struct packed {
      logic [4:0] set;
      logic [4:0] clr;
   } csb_cmd_s;
   // switch event pulses, per switch
   typedef struct packed {
      logic [4:0] on;
      logic [4:0] off;
   } csb_event_s;
   // led colour source selections for one button
   typedef struct packed {
      logic [3:0] red;
      logic [3:0] orange;
      logic [3:0] green;
   } csb_led_sel_s;
   // debouncer states
   typedef enum logic [0:0] {
      CSB_DB_STABLE = 1'h0,
      CSB_DB_SETTLE = 1'h1
   } csb_db_e;
endpackage

// file: csb_debounce.sv
// three-stage synchroniser and debouncer for one button pin
`include "csb_params.svh"
module csb_debounce (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // raw pin and clean level
   input wire logic pin_in,
   output logic level_out,
   output logic press_out
);
   logic s1_ff, s2_ff, s3_ff;
   logic [`CSB_DEB_CNT_W-1:0] cnt_ff;
   csb_pkg::csb_db_e state_ff;

   // synchroniser; first stage read only by the second
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         s1_ff <= 1'h0;
         s2_ff <= 1'h0;
         s3_ff <= 1'h0;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // level must sit steady for the debounce time before it is taken
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state_ff <= csb_pkg::CSB_DB_STABLE;
         cnt_ff <= '0;
         level_out <= 1'h0;
         press_out <= 1'h0;
      end else begin
         press_out <= 1'h0;
         case (state_ff)
            csb_pkg::CSB_DB_STABLE: begin
               cnt_ff <= '0;
               if (s2_ff == s3_ff && s3_ff != level_out) state_ff <= csb_pkg::CSB_DB_SETTLE; // [R14]
            end
            csb_pkg::CSB_DB_SETTLE: begin
               if (s2_ff != s3_ff || s3_ff == level_out) begin
                  state_ff <= csb_pkg::CSB_DB_STABLE;
               end else if (cnt_ff == `CSB_DEB_CNT_W'(`CSB_DEBOUNCE_CYC - 1)) begin
                  level_out <= s3_ff;
                  press_out <= s3_ff; // single press edge [R14]
                  state_ff <= csb_pkg::CSB_DB_STABLE;
               end else begin
                  cnt_ff <= cnt_ff + `CSB_DEB_CNT_W'(1);
               end
            end
            default: state_ff <= csb_pkg::CSB_DB_STABLE;
         endcase
      end
   end
endmodule // csb_debounce

// file: csb_top.sv
// control switches and front-panel user buttons
// Operation
// R1: five independent latching control switches each drive their own output.
// R2: a switch holds its state after a set or clear until the opposite command.
// R3: switches take commands only from the local display or the remote unit.
// R4: local commands act only when the session level meets the set minimum, configurator by default.
// R5: each switch change gives an on or off event pulse, each gated by its own enable.
// R6: twelve front-panel buttons each have their own mode and status output.
// R7: in momentary mode the status follows the held button.
// R8: in toggle mode the status inverts once per press.
// R9: mode is momentary or toggle per button, momentary after reset.
// R10: each button led has red, orange and green each driven from a chosen source.
// R11: button status changes only through the physical button.
// R12: each button gives complementary on and off outputs.
// R13: signals needing both local and remote control should use a switch, not a button.
// R14: button pins are synchronised and debounced, and toggling acts on one press edge.
`include "csb_params.svh"
module csb_top (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // switch commands: local display and remote unit
   input wire csb_pkg::csb_cmd_s local_cmd_in,
   input wire csb_pkg::csb_cmd_s remote_cmd_in,
   input wire csb_pkg::csb_level_e session_level_in,
   input wire csb_pkg::csb_level_e min_level_in,
   input wire logic [4:0] event_on_en_in,
   input wire logic [4:0] event_off_en_in,
   // buttons and configuration
   input wire logic [11:0] button_pin_in,
   input wire logic [11:0] toggle_mode_in,
   input wire csb_pkg::csb_led_sel_s [11:0] led_sel_in,
   input wire logic [`CSB_NUM_SOURCE-1:0] ext_signal_in,
   // switch outputs and events
   output logic [4:0] switch_out,
   output csb_pkg::csb_event_s event_out,
   // button outputs and leds
   output logic [11:0] button_on_out,
   output logic [11:0] button_off_out,
   output logic [11:0] led_red_out,
   output logic [11:0] led_orange_out,
   output logic [11:0] led_green_out
);
   // ****************************************
   // control switches
   // ****************************************
   logic local_ok;
   logic [4:0] set_req, clr_req, nxt_switch;

   // digital inputs and logic signals have no path here at all [R3]
   assign local_ok = session_level_in >= min_level_in; // [R4]
   assign set_req = remote_cmd_in.set | (local_ok ? local_cmd_in.set : 5'h0); // [R3]
   assign clr_req = remote_cmd_in.clr | (local_ok ? local_cmd_in.clr : 5'h0);
   // simultaneous set and clear: set wins, a deliberate tie-break
   assign nxt_switch = set_req | (switch_out & ~clr_req); // [R2]

   // latch per switch [R1]
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) switch_out <= 5'h0;
      else switch_out <= nxt_switch; // [R2]
   end

   // change events, enables pick which go to the buffer
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         event_out <= '0;
      end else begin
         event_out.on <= nxt_switch & ~switch_out & event_on_en_in; // [R5]
         event_out.off <= ~nxt_switch & switch_out & event_off_en_in; // [R5]
      end
   end

   // ****************************************
   // user buttons
   // ****************************************
   logic [11:0] level, press;
   logic [11:0] status_ff;

   genvar gi;
   generate
      for (gi = 0; gi < `CSB_NUM_BUTTON; gi++) begin : g_btn
         csb_debounce u_deb (
            .sys_clk_in(sys_clk_in),
            .reset_in(reset_in),
            .pin_in(button_pin_in[gi]),
            .level_out(level[gi]),
            .press_out(press[gi])
         ); // [R14]
      end
   endgenerate

   // status driven only by the debounced pin, no remote path [R11]; mode 0 is momentary [R9]
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         status_ff <= 12'h000;
      end else begin
         for (int i = 0; i < 12; i++) begin
            if (toggle_mode_in[i]) status_ff[i] <= status_ff[i] ^ press[i]; // [R8]
            else status_ff[i] <= level[i]; // [R7]
         end
      end
   end

   // complementary outputs [R12] [R6]
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         button_on_out <= 12'h000;
         button_off_out <= 12'hfff;
      end else begin
         button_on_out <= status_ff;
         button_off_out <= ~status_ff;
      end
   end

   // led source pick: code 0 is own status, else an external signal
   function automatic logic pick(input logic [3:0] sel, input logic own,
                                 input logic [`CSB_NUM_SOURCE-1:0] ext);
      logic r;
      r = (sel == 4'h0) ? own : ext[sel];
      return r;
   endfunction

   // leds; trades one external source (index 0) for own status
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         led_red_out <= 12'h000;
         led_orange_out <= 12'h000;
         led_green_out <= 12'h000;
      end else begin
         for (int i = 0; i < 12; i++) begin
            led_red_out[i] <= pick(led_sel_in[i].red, status_ff[i], ext_signal_in); // [R10]
            led_orange_out[i] <= pick(led_sel_in[i].orange, status_ff[i], ext_signal_in);
            led_green_out[i] <= pick(led_sel_in[i].green, status_ff[i], ext_signal_in);
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sw_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R2]
      (set_req == 5'h0 && clr_req == 5'h0) |=> $stable(switch_out))
      else $error("switch changed without command");
   sw_set_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R1]
      (remote_cmd_in.set[0]) |=> switch_out[0])
      else $error("remote set not taken");
   local_gate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R4]
      (session_level_in < min_level_in && remote_cmd_in == '0) |=> $stable(switch_out))
      else $error("local command taken at low level");
   ev_on_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      ($rose(switch_out[1]) && $past(event_on_en_in[1])) |-> event_out.on[1])
      else $error("missing on event");
   ev_off_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      event_out.off[2] |-> ($past(switch_out[2]) && !switch_out[2]))
      else $error("spurious off event");
   btn_comp_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R12]
      (button_on_out ^ button_off_out) == 12'hfff)
      else $error("button outputs not complementary");
   btn_mom_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R7]
      !toggle_mode_in[0] |=> status_ff[0] == $past(level[0]))
      else $error("momentary status wrong");
   btn_tog_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R8]
      (toggle_mode_in[1] && press[1]) |=> status_ff[1] != $past(status_ff[1]))
      else $error("toggle missed press");
   btn_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R11]
      (toggle_mode_in[1] && !press[1]) |=> $stable(status_ff[1]))
      else $error("toggle status moved without press");

   // any requested set lands on every addressed switch
   sw_set_all_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R1]
      (set_req != 5'h0) |=> (switch_out & $past(set_req)) == $past(set_req))
      else $error("set not latched");

   // a clear without a set empties the switch
   sw_clr_all_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R2]
      (clr_req != 5'h0) |=> (switch_out & $past(clr_req & ~set_req)) == 5'h0)
      else $error("clear not latched");

   // an on switch stays on until a clear arrives
   sw_on_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R2]
      (switch_out[1] && !clr_req[1]) |=> switch_out[1])
      else $error("switch dropped without clear");

   // an off switch stays off until a set arrives
   sw_off_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R2]
      (!switch_out[1] && !set_req[1]) |=> !switch_out[1])
      else $error("switch rose without set");

   // remote commands ignore the session level
   remote_set_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R3]
      remote_cmd_in.set[4] |=> switch_out[4])
      else $error("remote set lost");

   // remote clear acts when no set competes
   remote_clr_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R3]
      (remote_cmd_in.clr[4] && !set_req[4]) |=> !switch_out[4])
      else $error("remote clear lost");

   // local set acts once the level is high enough
   local_set_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R4]
      (session_level_in >= min_level_in && local_cmd_in.set[1]) |=> switch_out[1])
      else $error("local set lost");

   // local clear acts once the level is high enough
   local_clr_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R4]
      (session_level_in >= min_level_in && local_cmd_in.clr[0] && !set_req[0]) |=> !switch_out[0])
      else $error("local clear lost");

   // low level local set cannot raise a switch
   local_low_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R4]
      (session_level_in < min_level_in && !remote_cmd_in.set[2] && !switch_out[2]) |=> !switch_out[2])
      else $error("local set at low level");

   // on events only with their enable
   ev_on_gate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      event_out.on[0] |-> $past(event_on_en_in[0]))
      else $error("on event while disabled");

   // off events only with their enable
   ev_off_gate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      event_out.off[0] |-> $past(event_off_en_in[0]))
      else $error("off event while disabled");

   // an on event means the switch just rose
   ev_on_cause_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      event_out.on[3] |-> (switch_out[3] && !$past(switch_out[3])))
      else $error("spurious on event");

   // every enabled fall is reported
   ev_off_pair_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      ($fell(switch_out[4]) && $past(event_off_en_in[4])) |-> event_out.off[4])
      else $error("missing off event");

   // a held set never repeats its event
   ev_once_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      event_out.on[1] |=> !event_out.on[1])
      else $error("repeated on event");

   // on and off of one switch never together
   ev_excl_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      (event_out.on & event_out.off) == 5'h0)
      else $error("on and off together");

   // no change, no event
   ev_quiet_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R5]
      $stable(switch_out) |-> event_out == '0)
      else $error("event without change");

   // outputs follow status one cycle later
   btn_follow_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R6]
      1'b1 |=> button_on_out == $past(status_ff))
      else $error("button output lags wrongly");

   // a button with mode bit clear acts momentary
   btn_dflt_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R9]
      !toggle_mode_in[2] |=> status_ff[2] == $past(level[2]))
      else $error("default mode not momentary");

   // a released momentary button drops status
   btn_rel_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R7]
      (!toggle_mode_in[0] && !level[0]) |=> !status_ff[0])
      else $error("status held after release");

   // press edge only with a high level
   btn_press_lvl_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R14]
      press[1] |-> level[1])
      else $error("press without level");

   // press is a single cycle pulse
   btn_press_one_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R14]
      press[0] |=> !press[0])
      else $error("press longer than one cycle");

   // momentary status moves only with the debounced level
   btn_src_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R11]
      (!toggle_mode_in[0] && $stable(level[0])) |=> $stable(status_ff[0]))
      else $error("status moved without pin");

   // red from own status when selected
   led_red_own_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R10]
      (led_sel_in[0].red == 4'h0) |=> led_red_out[0] == $past(status_ff[0]))
      else $error("red not own status");

   // orange from an external signal when selected
   led_orange_ext_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R10]
      (led_sel_in[0].orange == 4'h3) |=> led_orange_out[0] == $past(ext_signal_in[3]))
      else $error("orange source wrong");

   // green from the top external signal when selected
   led_green_ext_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R10]
      (led_sel_in[0].green == 4'hf) |=> led_green_out[0] == $past(ext_signal_in[15]))
      else $error("green source wrong");

   // other buttons leds follow their own status by default
   led_other_a: assert property (@(posedge sys_clk_in) disable iff (reset_in) // [R10]
      (led_sel_in[1].green == 4'h0) |=> led_green_out[1] == $past(status_ff[1]))
      else $error("green own status wrong");
endmodule // csb_top

// file: csb_panel.sv
// front-panel operator model with contact bounce
module csb_panel (
   // clock
   input wire logic sys_clk_in,
   // requested and bouncing button levels
   input wire logic [11:0] press_in,
   output logic [11:0] button_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] last_ff = 12'h000;
   logic [11:0] mask_ff = 12'h000;
   logic [2:0] cnt_ff = 3'h0;
   initial button_pin_out = 12'h000;
   // contacts chatter six cycles after a change; no remote path reaches the pins
   always @(posedge sys_clk_in) begin
      last_ff <= press_in;
      if (press_in != last_ff) begin
         mask_ff <= press_in ^ last_ff;
         cnt_ff <= 3'h6;
      end else if (cnt_ff != 3'h0) begin
         cnt_ff <= cnt_ff - 3'h1;
      end
      button_pin_out <= (cnt_ff != 3'h0) ? (button_pin_out ^ mask_ff) : press_in;
   end
endmodule // csb_panel

// file: csb_top_bench.sv
// self-checking bench for the control switch and button block
module csb_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [9:0] loc, rem;
      logic [1:0] ses, lvl;
      logic [4:0] eon, eoff, sw;
      logic [9:0] ev;
   } csb_row_s;
   // ************
   // stimulus rows
   // ************
   // consecutive rows keep the previous command up one edge: a held command must not repeat events
   csb_row_s rows [9] = '{
      '{10'h000, 10'h020, 2'h2, 2'h2, 5'h1f, 5'h1f, 5'h01, 10'h020},
      '{10'h000, 10'h020, 2'h2, 2'h2, 5'h1f, 5'h1f, 5'h01, 10'h000},
      '{10'h040, 10'h000, 2'h2, 2'h2, 5'h1f, 5'h1f, 5'h03, 10'h040},
      '{10'h080, 10'h000, 2'h1, 2'h2, 5'h1f, 5'h1f, 5'h03, 10'h000},
      '{10'h001, 10'h000, 2'h3, 2'h3, 5'h1f, 5'h1f, 5'h02, 10'h001},
      '{10'h000, 10'h108, 2'h0, 2'h3, 5'h1f, 5'h1f, 5'h0a, 10'h100},
      '{10'h000, 10'h200, 2'h0, 2'h3, 5'h00, 5'h1f, 5'h1a, 10'h000},
      '{10'h000, 10'h01f, 2'h0, 2'h3, 5'h1f, 5'h1f, 5'h00, 10'h01a},
      '{10'h3e0, 10'h000, 2'h0, 2'h0, 5'h1f, 5'h1f, 5'h1f, 10'h3e0}};
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   csb_pkg::csb_cmd_s local_cmd_in = '0, remote_cmd_in = '0;
   csb_pkg::csb_level_e session_level_in = csb_pkg::CSB_LVL_USER, min_level_in = csb_pkg::CSB_LVL_CONFIGURATOR;
   logic [4:0] event_on_en_in = 5'h1f, event_off_en_in = 5'h1f;
   logic [11:0] press = 12'h000, button_pin_in, toggle_mode_in = 12'h002;
   csb_pkg::csb_led_sel_s [11:0] led_sel_in = {132'h0, 12'h03f};
   logic [15:0] ext_signal_in = 16'h0000;
   logic [4:0] switch_out;
   csb_pkg::csb_event_s event_out;
   logic [11:0] button_on_out, button_off_out, led_red_out, led_orange_out, led_green_out;
   int num_errors = 0;
   int checks = 0;
   // clock, 4 ns period
   always #2 sys_clk_in = ~sys_clk_in;
   csb_top u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .local_cmd_in(local_cmd_in),
      .remote_cmd_in(remote_cmd_in), .session_level_in(session_level_in), .min_level_in(min_level_in),
      .event_on_en_in(event_on_en_in), .event_off_en_in(event_off_en_in), .button_pin_in(button_pin_in),
      .toggle_mode_in(toggle_mode_in), .led_sel_in(led_sel_in), .ext_signal_in(ext_signal_in),
      .switch_out(switch_out), .event_out(event_out), .button_on_out(button_on_out),
      .button_off_out(button_off_out), .led_red_out(led_red_out), .led_orange_out(led_orange_out),
      .led_green_out(led_green_out));
   csb_panel u_panel (.sys_clk_in(sys_clk_in), .press_in(press), .button_pin_out(button_pin_in));
   // ************
   // helpers
   // ************
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   // press or release, then time the debounced answer
   task automatic btn(input int i, input logic lvl, input logic exp);
      int n;
      @(posedge sys_clk_in);
      press[i] <= lvl;
      n = 0;
      while (button_on_out[i] !== exp && n < 700) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      chk(n >= 500 && n < 700, "button timing");
      chk(button_off_out[i] === ~exp, "complement");
   endtask
   // change the pin and expect no change of status
   task automatic hold(input int i, input logic lvl, input logic exp);
      @(posedge sys_clk_in);
      press[i] <= lvl;
      repeat (600) @(posedge sys_clk_in);
      #1;
      chk(button_on_out[i] === exp, "button held");
   endtask
   task summarize;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ************
   // tests
   // ************
   initial begin
      repeat (10) @(posedge sys_clk_in);
      #1;
      chk(switch_out === 5'h00 && event_out === 10'h000 && button_on_out === 12'h000, "reset");
      chk(button_off_out === 12'hfff && led_red_out === 12'h000, "reset buttons");
      @(posedge sys_clk_in);
      reset_in <= 1'b0;
      foreach (rows[k]) begin
         @(posedge sys_clk_in);
         local_cmd_in <= rows[k].loc;
         remote_cmd_in <= rows[k].rem;
         session_level_in <= csb_pkg::csb_level_e'(rows[k].ses);
         min_level_in <= csb_pkg::csb_level_e'(rows[k].lvl);
         event_on_en_in <= rows[k].eon;
         event_off_en_in <= rows[k].eoff;
         @(posedge sys_clk_in);
         #1;
         chk(switch_out === rows[k].sw, "switch state");
         chk(event_out === rows[k].ev, "switch event");
         chk(button_on_out === 12'h000, "button moved by command");
      end
      @(posedge sys_clk_in);
      local_cmd_in <= '0;
      remote_cmd_in <= '0;
      reset_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk(switch_out === 5'h00 && event_out === 10'h000, "mid-run reset");
      @(posedge sys_clk_in);
      reset_in <= 1'b0;
      $display("test switch done");
      btn(0, 1'b1, 1'b1);
      chk(led_red_out[0] === 1'b1, "led own status");
      btn(0, 1'b0, 1'b0);
      btn(1, 1'b1, 1'b1);
      hold(1, 1'b0, 1'b1);
      btn(1, 1'b1, 1'b0);
      hold(1, 1'b0, 1'b0);
      // a 100-cycle tap is shorter than the debounce span
      @(posedge sys_clk_in);
      press[2] <= 1'b1;
      repeat (100) @(posedge sys_clk_in);
      hold(2, 1'b0, 1'b0);
      $display("test button done");
      @(posedge sys_clk_in);
      ext_signal_in <= 16'h8008;
      repeat (3) @(posedge sys_clk_in);
      #1;
      chk(led_orange_out === 12'h001 && led_green_out === 12'h001 && led_red_out === 12'h000, "led");
      $display("test led done");
      summarize();
   end
   // watchdog, about five times the expected run
   initial begin
      #80000;
      num_errors++;
      summarize();
   end
endmodule // csb_top_bench
